// file: pkg/ebs_map.svh
`ifndef EBS_MAP_SVH
`define EBS_MAP_SVH
// Chip config bit selecting byte-high-enable (1) or write-high strobe (0)
`define EBS_CFG_BHE_BIT 2
// Chip select 0 range after reset, internal addresses
`define EBS_CS0_RST_BASE 24'hFF_2000
`define EBS_CS0_RST_TOP 24'hFF_20FF
// Default range for chip selects 1 and 2 after reset: empty
`define EBS_CSX_RST_BASE 24'hFF_FFFF
`define EBS_CSX_RST_TOP 24'h00_0000
`define EBS_EXT_ADDR_W 21
`define EBS_CFG_RST 8'h04
`endif

// file: pkg/ebs_pkg.sv
package ebs_pkg;
	typedef enum logic [1:0] {
		EBS_IDLE = 2'b00,
		EBS_ADDR = 2'b01,
		EBS_DATA = 2'b11
	} ebs_state_t;
endpackage

// file: rtl/ebs_bus_ctrl.sv
// Functional notes
// R01 - 16-bit cycles: byte-high-enable low for word and high-byte accesses.
// R02 - Lanes: enable/bit0 00 both, 01 high only, 10 low only.
// R03 - Config bit 2: one gives byte-high-enable, zero gives write-high strobe.
// R04 - Bus request low during hold while an external cycle is pending.
// R05 - Bus request only when the bus-hold protocol is enabled.
// R06 - Chip select whose range holds the address goes low during the cycle.
// R07 - Address outside all ranges: no chip select, use chip select two config.
// R08 - After reset chip select zero covers FF2000 to FF20FF internally.
// R09 - Address latch strobe pulses high only at external cycle start.
// R10 - Only low 21 address bits appear on pins.
// R11 - All chip selects and byte enables high when no cycle runs.
`timescale 1ns/1ps
`default_nettype none
`include "ebs_map.svh"
module ebs_bus_ctrl
	import ebs_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int NCS = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Internal cycle request
	input wire logic cyc_req,
	input wire logic [ADDR_W-1:0] cyc_addr,
	input wire logic cyc_write,
	input wire logic cyc_word,
	output logic cyc_done,
	// Configuration
	input wire logic [7:0] chip_config_reg0,
	input wire logic hold_enable,
	input wire logic hold_active,
	input wire logic range_load,
	input wire logic [1:0] range_sel,
	input wire logic [ADDR_W-1:0] range_base,
	input wire logic [ADDR_W-1:0] range_top,
	input wire logic [NCS-1:0] cs_bus16,
	// Pins
	output logic [`EBS_EXT_ADDR_W-1:0] ext_addr,
	output logic addr_data_bit0,
	output logic ale,
	output logic byte_high_enable_n,
	output logic [NCS-1:0] chip_select_n,
	output logic bus_request_n,
	output logic cyc_bus16
);
	// ======================================================
	// Parameter check
	// Decode priority and reset ranges are written for three chip selects
	if (NCS != 3 || ADDR_W < `EBS_EXT_ADDR_W) begin : g_bad_param
		$error("ebs_bus_ctrl: bad parameters");
	end

	// ======================================================
	// Chip select ranges
	logic [ADDR_W-1:0] base_r [NCS];
	logic [ADDR_W-1:0] top_r [NCS];
	logic [ADDR_W-1:0] base_nxt [NCS];
	logic [ADDR_W-1:0] top_nxt [NCS];
	logic [NCS-1:0] hit;

	genvar gi;
	generate
		for (gi = 0; gi < NCS; gi++) begin : g_cs
			always_comb begin
				base_nxt[gi] = base_r[gi];
				top_nxt[gi] = top_r[gi];
				if (range_load && range_sel == 2'(gi)) begin
					base_nxt[gi] = range_base;
					top_nxt[gi] = range_top;
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					base_r[gi] <= (gi == 0) ? ADDR_W'(`EBS_CS0_RST_BASE) : ADDR_W'(`EBS_CSX_RST_BASE); // R08
					top_r[gi] <= (gi == 0) ? ADDR_W'(`EBS_CS0_RST_TOP) : ADDR_W'(`EBS_CSX_RST_TOP); // R08
				end else begin
					base_r[gi] <= base_nxt[gi];
					top_r[gi] <= top_nxt[gi];
				end
			end
			// Compare on the low 21 bits so internal and external images match
			assign hit[gi] = cyc_addr[`EBS_EXT_ADDR_W-1:0] >= base_r[gi][`EBS_EXT_ADDR_W-1:0]
				&& cyc_addr[`EBS_EXT_ADDR_W-1:0] <= top_r[gi][`EBS_EXT_ADDR_W-1:0]; // R06
		end
	endgenerate

	// ======================================================
	// Target decode
	logic [NCS-1:0] sel;
	logic b16;
	logic hi_lane;
	logic bhe_take;

	always_comb begin
		// Lowest numbered range wins on overlap
		sel = '0;
		if (hit[0]) begin
			sel = NCS'(1);
		end else if (hit[1]) begin
			sel = NCS'(2);
		end else if (hit[2]) begin
			sel = NCS'(4);
		end
		// Unmapped cycles borrow the width of chip select two
		b16 = (sel == '0) ? cs_bus16[NCS-1] : |(sel & cs_bus16); // R07
		// High lane used for word or odd byte access
		hi_lane = cyc_word || cyc_addr[0]; // R02
		// Write-high strobe mode drops the pin on high-lane writes only
		if (chip_config_reg0[`EBS_CFG_BHE_BIT]) begin
			bhe_take = !(b16 && hi_lane); // R01 R03
		end else begin
			bhe_take = !(b16 && hi_lane && cyc_write); // R03
		end
	end

	// ======================================================
	// Cycle sequencer
	ebs_state_t state_r;
	ebs_state_t state_nxt;
	logic [NCS-1:0] cs_r;
	logic [NCS-1:0] cs_nxt;
	logic bhe_r;
	logic bhe_nxt;
	logic ale_r;
	logic ale_nxt;
	logic done_r;
	logic done_nxt;
	logic b16_r;
	logic b16_nxt;
	logic a0_r;
	logic a0_nxt;
	logic [`EBS_EXT_ADDR_W-1:0] addr_r;
	logic [`EBS_EXT_ADDR_W-1:0] addr_nxt;
	logic take;

	// Requester holds its request until it sees done, so the done
	// cycle must not start a second transfer on that same request
	assign take = cyc_req && !hold_active && !done_r;

	always_comb begin
		state_nxt = state_r;
		cs_nxt = '1; // R11
		bhe_nxt = 1'b1; // R11
		ale_nxt = 1'b0;
		done_nxt = 1'b0;
		b16_nxt = b16_r;
		a0_nxt = a0_r;
		addr_nxt = addr_r;
		case (state_r)
			EBS_IDLE: begin
				if (take) begin
					state_nxt = EBS_ADDR;
					ale_nxt = 1'b1; // R09
					addr_nxt = cyc_addr[`EBS_EXT_ADDR_W-1:0]; // R10
					a0_nxt = cyc_word ? 1'b0 : cyc_addr[0]; // R02
					b16_nxt = b16;
					cs_nxt = ~sel; // R06 R07
					bhe_nxt = bhe_take; // R01 R03
				end
			end
			EBS_ADDR: begin
				// Strobes stand through the address and data cycles only
				state_nxt = EBS_DATA;
				cs_nxt = cs_r;
				bhe_nxt = bhe_r;
			end
			EBS_DATA: begin
				state_nxt = EBS_IDLE;
				done_nxt = 1'b1;
			end
			default: begin
				state_nxt = EBS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= EBS_IDLE;
			cs_r <= '1; // R11
			bhe_r <= 1'b1; // R11
			ale_r <= 1'b0;
			done_r <= 1'b0;
			b16_r <= 1'b0;
			a0_r <= 1'b0;
			addr_r <= '0;
		end else begin
			state_r <= state_nxt;
			cs_r <= cs_nxt;
			bhe_r <= bhe_nxt;
			ale_r <= ale_nxt;
			done_r <= done_nxt;
			b16_r <= b16_nxt;
			a0_r <= a0_nxt;
			addr_r <= addr_nxt;
		end
	end

	// ======================================================
	// Bus request during hold
	logic bus_request_n_r;
	logic bus_request_n_nxt;

	// Registered for a clean pin, so it follows the request one cycle late
	always_comb begin
		bus_request_n_nxt = !(hold_enable && hold_active && cyc_req); // R04 R05
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_request_n_r <= 1'b1;
		end else begin
			bus_request_n_r <= bus_request_n_nxt;
		end
	end

	// ======================================================
	// Pins
	assign chip_select_n = cs_r;
	assign byte_high_enable_n = bhe_r;
	assign ale = ale_r;
	assign cyc_done = done_r;
	assign cyc_bus16 = b16_r;
	assign addr_data_bit0 = a0_r;
	assign ext_addr = addr_r;
	assign bus_request_n = bus_request_n_r;
endmodule
`default_nettype wire

// file: testbench/ebs_bus_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ebs_chk (
	// Clock, reset, inputs
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cyc_req,
	input wire logic [23:0] cyc_addr,
	input wire logic [7:0] chip_config_reg0,
	input wire logic hold_enable,
	input wire logic hold_active,
	// Pins
	input wire logic [20:0] ext_addr,
	input wire logic addr_data_bit0,
	input wire logic ale,
	input wire logic byte_high_enable_n,
	input wire logic [2:0] chip_select_n,
	input wire logic bus_request_n,
	input wire logic cyc_done,
	input wire logic cyc_bus16
);
	// ====
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	ale_done_a: assert property (ale |-> ##2 cyc_done) else $error("no done");
	ale_pulse_a: assert property (ale |=> !ale[*2]) else $error("ale long");
	idle_high_a: assert property (!ale && !$past(ale) |->
		&chip_select_n && byte_high_enable_n) else $error("idle low");
	cs_one_a: assert property ($onehot0(~chip_select_n)) else $error("two cs");
	wide_only_a: assert property (!byte_high_enable_n |-> cyc_bus16) else $error("bhe8");
	lane_code_a: assert property (ale && cyc_bus16 && chip_config_reg0[2] |->
		{byte_high_enable_n, addr_data_bit0} != 2'b11) else $error("lane");
	bus_request_n_on_a: assert property (hold_enable && hold_active && cyc_req |=>
		!bus_request_n) else $error("no bus_request_n");
	bus_request_n_off_a: assert property (!hold_enable |=> bus_request_n) else $error("bus_request_n");
	addr_pins_a: assert property (ale |-> ext_addr == $past(cyc_addr[20:0]))
		else $error("addr");
	done_gap_a: assert property (cyc_done |=> !ale) else $error("retake");
	cs0_c: cover property (ale && !chip_select_n[0]);
	strobe_c: cover property (ale && !chip_config_reg0[2] && !byte_high_enable_n);
	bus_request_n_c: cover property (!bus_request_n);
	unmap_c: cover property (ale && &chip_select_n);
endmodule
bind ebs_bus_ctrl ebs_chk i_ebs_chk(.clk, .reset_n, .cyc_req, .cyc_addr, .chip_config_reg0,
	.hold_enable, .hold_active, .ext_addr, .addr_data_bit0, .ale, .byte_high_enable_n,
	.chip_select_n, .bus_request_n, .cyc_done, .cyc_bus16);
`default_nettype wire

// file: testbench/ebs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebs_mem_model (
	// Bus
	input wire logic clk,
	input wire logic ale,
	input wire logic [20:0] ext_addr,
	// Latched address
	output logic [20:0] lat_addr
);
	always_ff @(posedge clk) if (ale) lat_addr <= ext_addr;
endmodule
`default_nettype wire

// file: testbench/test_ebs_bus_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_ebs_bus_ctrl;
	logic clk, reset_n, cyc_req, cyc_write, cyc_word, cyc_done, hold_enable, hold_active;
	logic range_load, addr_data_bit0, ale, byte_high_enable_n, bus_request_n, cyc_bus16, bh, a0, b;
	logic [23:0] cyc_addr, range_base, range_top;
	logic [7:0] chip_config_reg0;
	logic [1:0] range_sel;
	logic [2:0] cs_bus16, chip_select_n, cs;
	logic [20:0] ext_addr, lat_addr;
	int n_fail = 0, total_checks = 0, cycles = 0;
	ebs_bus_ctrl i_ebs_bus_ctrl(.clk, .reset_n, .cyc_req, .cyc_addr, .cyc_write, .cyc_word,
		.cyc_done, .chip_config_reg0, .hold_enable, .hold_active, .range_load, .range_sel,
		.range_base, .range_top, .cs_bus16, .ext_addr, .addr_data_bit0, .ale,
		.byte_high_enable_n, .chip_select_n, .bus_request_n, .cyc_bus16);
	ebs_mem_model i_ebs_mem_model(.clk, .ale, .ext_addr, .lat_addr);
	task automatic chk(input string n, input logic [23:0] e, g);
		total_checks++;
		if (e !== g) begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Request stands until done is sampled high; done follows ale by two edges
	task automatic cyc(input logic [23:0] a, input logic w, input logic wr);
		int n;
		n = 0;
		@(posedge clk);
		cyc_req <= 1'b1;
		cyc_addr <= a;
		cyc_word <= w;
		cyc_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (!ale && n < 9);
		{cs, bh, a0, b} = {chip_select_n, byte_high_enable_n, addr_data_bit0, cyc_bus16};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!cyc_done && n < 9);
		cyc_req <= 1'b0;
		chk("done", 2, n);
	endtask
	task automatic t_lanes;
		cyc(24'hFF_2010, 1'b1, 1'b0);
		chk("word", 5'b11000, {cs, bh, a0});
		chk("latch", 21'h1F_2010, lat_addr);
		cyc(24'hFF_2011, 1'b0, 1'b1);
		chk("hi", 2'b01, {bh, a0});
		cyc(24'hFF_2010, 1'b0, 1'b0);
		chk("lo", 2'b10, {bh, a0});
		@(posedge clk) chip_config_reg0 <= 8'h00;
		cyc(24'hFF_2011, 1'b0, 1'b0);
		chk("strobe rd", 1, bh);
		cyc(24'hFF_2011, 1'b0, 1'b1);
		chk("strobe wr", 0, bh);
		@(posedge clk) chip_config_reg0 <= 8'h04;
	endtask
	task automatic t_reset;
		@(posedge clk);
		range_load <= 1'b1;
		range_sel <= 2'd0;
		range_base <= 24'h00_0000;
		range_top <= 24'h00_000F;
		@(posedge clk) range_load <= 1'b0;
		@(posedge clk) reset_n <= 1'b0;
		@(negedge clk);
		chk("rst pins", 5'b11111, {chip_select_n, byte_high_enable_n, bus_request_n});
		@(posedge clk) reset_n <= 1'b1;
		cyc(24'h1F_2000, 1'b1, 1'b0);
		chk("rst cs0", 5'b11000, {cs, bh, a0});
		cyc(24'hFF_20FF, 1'b0, 1'b0);
		chk("rst top", 5'b11001, {cs, bh, a0});
	endtask
	task automatic t_map;
		cyc(24'h00_0100, 1'b1, 1'b0);
		chk("unmap", 5'b11101, {cs, b, bh});
		@(posedge clk);
		range_load <= 1;
		range_sel <= 1;
		range_base <= 24'h01_0000;
		range_top <= 24'h01_FFFF;
		@(posedge clk) range_load <= 0;
		cyc(24'h01_FFFF, 1'b0, 1'b0);
		chk("cs1", 5'b10101, {cs, bh, a0});
	endtask
	task automatic t_hold;
		@(posedge clk);
		{hold_enable, hold_active, cyc_req} <= 3'b111;
		repeat (3) @(negedge clk);
		chk("bus_request_n", 2'b00, {bus_request_n, ale});
		@(posedge clk) hold_enable <= 0;
		repeat (2) @(negedge clk);
		chk("bus_request_n off", 1, bus_request_n);
		@(posedge clk) {hold_active, cyc_req} <= 2'b00;
	endtask
	task final_report;
		if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		{reset_n, cyc_req, cyc_write, cyc_word, hold_enable, hold_active, range_load} = 0;
		{cyc_addr, range_base, range_top, range_sel} = 0;
		chip_config_reg0 = 8'h04;
		cs_bus16 = 3'b011;
		repeat (20) @(posedge clk);
		reset_n <= 1;
		t_lanes;
		t_map;
		t_hold;
		t_reset;
		final_report;
	end
endmodule
`default_nettype wire
